// ===== hw/rxen_train_top.sv
// Read strobe training registers and phy measurement control
`timescale 1ns/1ps
module rxen_train_top #(
    parameter int LANES = 8 // 8-bit lanes
) (
    input wire logic clock, // 200 MHz clock
    input wire logic srst, // Sync reset, active high
    input wire logic [7:0] addr, // Register address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [31:0] rdata, // Read data, one cycle later
    input wire logic [LANES-1:0] strobe_pin, // Read strobe pads
    output logic [LANES*10-1:0] rx_enable_delay, // Per-lane coarse/fine delay
    output logic rx_pointer_reinit // Receive pointer reinit pulse
);
    typedef enum {IDLE, REINIT} ptr_state_e;

    logic rx_enable_training_enable_r;
    logic rx_enable_training_enable_nxt;
    logic [1:0] training_dimm_select_r;
    logic [1:0] training_dimm_select_nxt;
    logic [2:0] lane_sel_r;
    logic [2:0] lane_sel_nxt;
    rxen_train_pkg::phase_s seed_r [LANES];
    rxen_train_pkg::phase_s seed_nxt [LANES];
    rxen_train_pkg::phase_s meas [LANES];
    logic [LANES-1:0] load;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    ptr_state_e pst_r;
    ptr_state_e pst_nxt;
    logic [7:0] pcnt_r;
    logic [7:0] pcnt_nxt;
    logic reinit_r;
    logic reinit_nxt;
    logic [LANES*10-1:0] dly_r;
    logic [LANES*10-1:0] dly_nxt;

    // ------------------------------------------------------------
    // Address decode shared by the write paths
    // ------------------------------------------------------------
    // One compare for every write decode, so the registers can never
    // disagree about which offset a strobe hit
    function automatic logic reg_hit(input logic strobe, input logic [7:0] a,
        input logic [7:0] offset);
        return strobe && (a == offset);
    endfunction

    // ------------------------------------------------------------
    // Per-lane phase meters
    // ------------------------------------------------------------
    // Every lane meters at once; only the selected lane is visible on the
    // result register, so software walks the lanes after training ends
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        strobe_phase_meter u_meter (
            .clock(clock),
            .srst(srst),
            .enable(rx_enable_training_enable_r),
            .load(load[g]),
            .seed(seed_r[g]),
            .strobe_pin(strobe_pin[g]),
            .result(meas[g])
        );
    end

    // ------------------------------------------------------------
    // Register writes and reads
    // ------------------------------------------------------------
    // Seed load pulses when enable rises, so meters start from the seed
    always_comb begin
        rx_enable_training_enable_nxt = rx_enable_training_enable_r;
        training_dimm_select_nxt = training_dimm_select_r;
        lane_sel_nxt = lane_sel_r;
        for (int i = 0; i < LANES; i++) begin
            seed_nxt[i] = seed_r[i];
        end
        load = '0;
        dly_nxt = dly_r;
        if (reg_hit(wr, addr, rxen_train_pkg::REG_CTRL)) begin
            rx_enable_training_enable_nxt = wdata[rxen_train_pkg::CTRL_EN_BIT];
            training_dimm_select_nxt = wdata[rxen_train_pkg::CTRL_DIMM_LSB +: 2];
            lane_sel_nxt = wdata[10:8];
            if (wdata[rxen_train_pkg::CTRL_EN_BIT] && !rx_enable_training_enable_r) begin
                load = '1;
            end
        end
        // A seed write also loads the lane delay, so results are programmed the same way
        if (reg_hit(wr, addr, rxen_train_pkg::REG_SEED)) begin
            // Seed in 1/32 UI steps, software-split coarse and fine
            seed_nxt[lane_sel_r].fine = wdata[4:0];
            seed_nxt[lane_sel_r].coarse = wdata[rxen_train_pkg::SEED_COARSE_LSB +: 5];
            dly_nxt[lane_sel_r*10 +: 10] = {wdata[12:8], wdata[4:0]};
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Zero outside the answer cycle, so several slaves can share one return bus
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (rd) begin
            case (addr)
                rxen_train_pkg::REG_CTRL: rdata_nxt = {21'h000000, lane_sel_r, 2'h0,
                    training_dimm_select_r, 3'h0, rx_enable_training_enable_r};
                rxen_train_pkg::REG_SEED: rdata_nxt = {19'h00000, seed_r[lane_sel_r].coarse,
                    3'h0, seed_r[lane_sel_r].fine};
                rxen_train_pkg::REG_RESULT: rdata_nxt = {19'h00000, meas[lane_sel_r].coarse,
                    3'h0, meas[lane_sel_r].fine};
                rxen_train_pkg::REG_PTR: rdata_nxt = {31'h0, pst_r == REINIT};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receive pointer reinit handshake
    // ------------------------------------------------------------
    // Bit reads one until pointers are reinitialised, then self-clears
    always_comb begin
        pst_nxt = pst_r;
        pcnt_nxt = pcnt_r;
        reinit_nxt = 1'b0;
        case (pst_r)
            IDLE: begin
                if (reg_hit(wr, addr, rxen_train_pkg::REG_PTR)
                    && wdata[rxen_train_pkg::PTR_REQ_BIT]) begin
                    pst_nxt = REINIT;
                    pcnt_nxt = 8'(rxen_train_pkg::PTR_INIT_CYC);
                    reinit_nxt = 1'b1;
                end
            end
            REINIT: begin
                // Requests are ignored here; busy reads one until the count runs out
                if (pcnt_r <= 8'h01) begin
                    pst_nxt = IDLE;
                end else begin
                    pcnt_nxt = pcnt_r - 8'h01;
                end
            end
            default: pst_nxt = IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Configuration, seeds and lane delays; read data kept apart so the
    // answer path stays a single flop behind its mux
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_enable_training_enable_r <= 1'b0;
            training_dimm_select_r <= 2'h0;
            lane_sel_r <= 3'h0;
            for (int i = 0; i < LANES; i++) begin
                seed_r[i] <= '0;
            end
            dly_r <= '0;
        end else begin
            rx_enable_training_enable_r <= rx_enable_training_enable_nxt;
            training_dimm_select_r <= training_dimm_select_nxt;
            lane_sel_r <= lane_sel_nxt;
            for (int i = 0; i < LANES; i++) begin
                seed_r[i] <= seed_nxt[i];
            end
            dly_r <= dly_nxt;
        end
    end

    // Read data stands for one cycle only
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Pointer handshake; the pulse is registered so the output is a flop
    always_ff @(posedge clock) begin
        if (srst) begin
            pst_r <= IDLE;
            pcnt_r <= 8'h00;
            reinit_r <= 1'b0;
        end else begin
            pst_r <= pst_nxt;
            pcnt_r <= pcnt_nxt;
            reinit_r <= reinit_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Straight from flops, so no decode glitch reaches the phy
    assign rdata = rdata_r;
    assign rx_enable_delay = dly_r;
    assign rx_pointer_reinit = reinit_r;
endmodule

// ===== hw/rxen_train_pkg.sv
// Package with constants and carrier types for the read strobe training logic
package rxen_train_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte offset on the plain port)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SEED = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;
    localparam logic [7:0] REG_PTR = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_DIMM_LSB = 4;
    localparam int PTR_REQ_BIT = 0;
    localparam int SEED_COARSE_LSB = 8;
    localparam int FINE_W = 5;
    localparam int COARSE_W = 5;
    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [FINE_W-1:0] FINE_RST = 5'h00;
    localparam logic [COARSE_W-1:0] COARSE_RST = 5'h00;
    localparam logic [COARSE_W-1:0] PHY_FIXED_OFFSET = 5'h02;
    localparam int PTR_INIT_NS = 40;
    localparam int CLK_MHZ = 200;
    localparam int PTR_INIT_CYC = (PTR_INIT_NS * CLK_MHZ + 999) / 1000;
    // Phase result for one lane
    typedef struct packed {
        logic [COARSE_W-1:0] coarse;
        logic [FINE_W-1:0] fine;
    } phase_s;
endpackage

// ===== hw/strobe_phase_meter.sv
// Per-lane phase meter for received read strobe edges
`timescale 1ns/1ps
module strobe_phase_meter (
    input wire logic clock, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic enable, // Training enabled
    input wire logic load, // Load seed values
    input wire rxen_train_pkg::phase_s seed, // Seed coarse and fine
    input wire logic strobe_pin, // Raw strobe from pad
    output rxen_train_pkg::phase_s result // Recovered phase
);
    logic [2:0] sync_r;
    logic [2:0] sync_nxt;
    logic [9:0] cnt_r;
    logic [9:0] cnt_nxt;
    logic [9:0] wait_r;
    logic [9:0] wait_nxt;
    rxen_train_pkg::phase_s res_r;
    rxen_train_pkg::phase_s res_nxt;
    logic level_r;
    logic level_nxt;
    logic rise;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Edge taken once stages two and three agree on high while the level was low,
    // so a pad glitch shorter than a cycle never counts
    always_comb begin
        sync_nxt = {sync_r[1:0], strobe_pin};
        level_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : level_r;
        rise = sync_r[1] & sync_r[2] & ~level_r;
        cnt_nxt = cnt_r;
        wait_nxt = wait_r;
        res_nxt = res_r;
        if (load) begin
            res_nxt = seed;
            // Fixed internal offset added before sampling begins
            wait_nxt = {5'h00, seed.coarse} + {5'h00, rxen_train_pkg::PHY_FIXED_OFFSET};
            cnt_nxt = 10'h000;
        end else if (enable) begin
            if (wait_r != 10'h000) begin
                wait_nxt = wait_r - 10'h001;
            end else begin
                cnt_nxt = cnt_r + 10'h001;
                if (rise) begin
                    // Phase of edge against reference count
                    res_nxt.coarse = cnt_r[9:5];
                    res_nxt.fine = cnt_r[4:0];
                    cnt_nxt = 10'h000;
                end
            end
        end
    end

    // Registers only
    always_ff @(posedge clock) begin
        if (srst) begin
            sync_r <= 3'h0;
            level_r <= 1'b0;
            cnt_r <= 10'h000;
            wait_r <= 10'h000;
            res_r <= '0;
        end else begin
            sync_r <= sync_nxt;
            level_r <= level_nxt;
            cnt_r <= cnt_nxt;
            wait_r <= wait_nxt;
            res_r <= res_nxt;
        end
    end

    assign result = res_r;
endmodule

// ===== dv/rxen_train_checker_assertions.sv
// Port-level assertions for the read strobe training block
`timescale 1ns/1ps
module rxen_train_checker #(
    parameter int LANES = 8 // Lane count
) (
    input wire logic clock, // Clock
    input wire logic srst, // Sync reset
    input wire logic [7:0] addr, // Register address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    input wire logic [31:0] rdata, // Read data
    input wire logic [LANES-1:0] strobe_pin, // Strobe pads
    input wire logic [LANES*10-1:0] rx_enable_delay, // Lane delays
    input wire logic rx_pointer_reinit // Reinit pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // Reinit pulse needs a request and may not retrigger while busy
    property p_pulse_cause;
        rx_pointer_reinit |-> $past(wr) && $past(addr) == rxen_train_pkg::REG_PTR && $past(wdata[0]);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause)
        else $error("reinit pulse without request");
    property p_pulse_gap;
        rx_pointer_reinit |=> !rx_pointer_reinit [*8];
    endproperty
    a_pulse_gap: assert property (p_pulse_gap)
        else $error("reinit retriggered while busy");
    // Delays only move on a seed write
    property p_delay_cause;
        !$stable(rx_enable_delay) |-> $past(wr) && $past(addr) == rxen_train_pkg::REG_SEED;
    endproperty
    a_delay_cause: assert property (p_delay_cause)
        else $error("lane delay changed without seed write");
    // Read data is only driven in the cycle after a read
    property p_read_idle;
        !$past(rd) |-> rdata == 32'h0000_0000;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read data outside answer cycle");
    c_pulse: cover property (rx_pointer_reinit);
    c_seed: cover property (wr && addr == rxen_train_pkg::REG_SEED);
    c_result: cover property (rd && addr == rxen_train_pkg::REG_RESULT);
endmodule
bind rxen_train_top rxen_train_checker #(.LANES(LANES)) u_chk (.clock(clock), .srst(srst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .strobe_pin(strobe_pin),
    .rx_enable_delay(rx_enable_delay), .rx_pointer_reinit(rx_pointer_reinit));

// ===== dv/dimm_strobe_model.sv
// Behavioural memory-side read strobe source
`timescale 1ns/1ps
module dimm_strobe_model #(
    parameter int LANES = 8 // Lane count
) (
    input wire logic clock, // System clock
    input wire logic go, // Read stream active
    input wire logic [9:0] delay, // Cycles to first strobe edge
    output logic [LANES-1:0] strobe // Strobe per lane
);
    int cnt;
    // Strobe rises when the read stream reaches the pins, parks low when idle
    always_ff @(posedge clock) begin
        if (!go) begin
            cnt <= 0;
            strobe <= '0;
        end else begin
            cnt <= cnt + 1;
            if (cnt == int'(delay)) begin
                strobe <= '1;
            end
        end
    end
endmodule

// ===== dv/test_ddr3_read_strobe_training.sv
// Self-checking bench for the read strobe training block
`timescale 1ns/1ps
module test_ddr3_read_strobe_training;
    localparam int LANES = 8;
    logic clock = 0, srst = 1, wr = 0, rd = 0, go = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [9:0] dly = 10'h000;
    logic [LANES-1:0] strobe_pin;
    logic [LANES*10-1:0] rx_enable_delay;
    logic rx_pointer_reinit;
    int bad_count = 0, checks_done = 0, pulses = 0;
    initial begin
        forever #2.5 clock = ~clock;
    end
    rxen_train_top #(.LANES(LANES)) u_dut (.clock(clock), .srst(srst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .strobe_pin(strobe_pin),
        .rx_enable_delay(rx_enable_delay), .rx_pointer_reinit(rx_pointer_reinit));
    dimm_strobe_model #(.LANES(LANES)) u_mem (.clock(clock), .go(go), .delay(dly),
        .strobe(strobe_pin));
    // Count reinit pulses so a refused request shows up
    always @(posedge clock) begin
        if (rx_pointer_reinit === 1'b1) pulses++;
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 0;
    endtask
    task rd_reg(input logic [7:0] a, output logic [31:0] q);
        @(posedge clock);
        rd <= 1;
        addr <= a;
        @(posedge clock);
        rd <= 0;
        #1 q = rdata;
    endtask
    function logic [31:0] seed_word(input logic [4:0] c, input logic [4:0] f);
        return {19'h0, c, 3'h0, f};
    endfunction
    // Firmware seed arithmetic in 1/32 UI steps; the integer divide is the floor
    localparam int rx_enable_seed_offset = 32'h0000_005B;
    function automatic int total_seed(input int pass, input int prev, input int f_new,
        input int f_old);
        if (pass == 0) begin
            return rx_enable_seed_offset + prev;
        end
        return ((prev - 32'h0000_0020) * f_new) / f_old;
    endfunction
    function automatic int seed_pre_coarse(input int total);
        return ((total / 32) % 2 == 1) ? 1 : 2;
    endfunction
    function automatic int final_coarse(input int total, input int rec);
        return total / 32 + rec - seed_pre_coarse(total) + 1;
    endfunction
    // One enable window on lane 3; strobe edge arrives d cycles in
    task measure(input int d, output logic [9:0] r);
        logic [31:0] q;
        wr_reg(rxen_train_pkg::REG_CTRL, 32'h0000_0310);
        dly <= 10'(d);
        @(posedge clock);
        go <= 1;
        wr <= 1;
        addr <= rxen_train_pkg::REG_CTRL;
        wdata <= 32'h0000_0311;
        @(posedge clock);
        wr <= 0;
        repeat (d + 40) @(posedge clock);
        wr_reg(rxen_train_pkg::REG_CTRL, 32'h0000_0310);
        go <= 0;
        rd_reg(rxen_train_pkg::REG_RESULT, q);
        r = {q[12:8], q[4:0]};
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog well past the expected run length
    initial begin
        #100000;
        bad_count++;
        give_verdict;
    end
    initial begin
        logic [31:0] q;
        logic [4:0] c, f;
        logic [9:0] r0, r1;
        int d, n;
        int tot, tot3;
        void'($urandom(19552));
        repeat (16) @(posedge clock);
        srst <= 0;
        @(posedge clock);
        #1 check("delay after reset", rx_enable_delay[31:0], 32'h0);
        rd_reg(rxen_train_pkg::REG_RESULT, q);
        check("result after reset", q, 32'h0);
        $display("test reset done");
        for (int l = 0; l < LANES; l++) begin
            // Odd lanes carry a later-pass seed, lanes 2, 4 and 6 a first-pass one, lane 0 the top seed 0x3FF
            tot = total_seed(l % 2, 32 + $urandom_range(0, 703), 4, 3);
            if (l == 0) tot = 32'h0000_03FF;
            if (l == 3) tot3 = tot;
            c = 5'(tot / 32);
            f = 5'(tot % 32);
            wr_reg(rxen_train_pkg::REG_CTRL, 32'(l) << 8);
            rd_reg(rxen_train_pkg::REG_CTRL, q);
            check("lane select", q, 32'(l) << 8);
            wr_reg(rxen_train_pkg::REG_SEED, seed_word(c, f));
            rd_reg(rxen_train_pkg::REG_SEED, q);
            check("seed readback", q, seed_word(c, f));
            check("lane delay", 32'(rx_enable_delay[l*10+:10]), 32'({c, f}));
        end
        $display("test seeds done");
        d = 40 + $urandom_range(0, 200);
        measure(d, r0);
        measure(d + 32, r1);
        check("phase step 32", 32'(r1 - r0), 32'd32);
        measure(d + 1, r1);
        check("phase step 1", 32'(r1 - r0), 32'd1);
        // Recovered phase folded back into lane 3 as firmware would
        c = 5'(final_coarse(tot3, int'(r0[9:5])));
        wr_reg(rxen_train_pkg::REG_SEED, seed_word(c, r0[4:0]));
        #1 check("programmed delay", 32'(rx_enable_delay[39:30]), 32'({c, r0[4:0]}));
        $display("test phase done");
        // Sweep steps, each closed by a pointer reinit; the last one also
        // tries a second request while busy, which must be refused
        for (int s = 0; s < 4; s++) begin
            wr_reg(rxen_train_pkg::REG_PTR, 32'h1);
            rd_reg(rxen_train_pkg::REG_PTR, q);
            check("pointer busy", q, 32'h1);
            if (s == 3) begin
                wr_reg(rxen_train_pkg::REG_PTR, 32'h1);
            end
            n = 0;
            while (q[0] === 1'b1 && n < 10) begin
                rd_reg(rxen_train_pkg::REG_PTR, q);
                n++;
            end
            check("pointer cleared", q, 32'h0);
            check("poll count", 32'(n + (s == 3)),
                32'(rxen_train_pkg::PTR_INIT_CYC / 2));
        end
        check("reinit pulses", 32'(pulses), 32'd4);
        $display("test pointer done");
        wr_reg(8'h20, $urandom);
        rd_reg(8'h20, q);
        check("unmapped read", q, 32'h0);
        rd_reg(rxen_train_pkg::REG_STATUS, q);
        check("reserved read", q, 32'h0);
        $display("test unmapped done");
        give_verdict;
    end
endmodule
